// ===== cbr_pkg.sv
/* cbr_pkg: constants, types and shared arithmetic of the channel back end.
   assumes one 40 MHz clock and 32-bit AXI4-Lite register access. */
package cbr_pkg;
  // sample, coefficient and storage sizes
  localparam int DW   = 20;
  localparam int HCW  = 6;
  localparam int DCW  = 14;
  localparam int NDL  = 128;
  localparam int NRAM = 64;
  // register byte offsets
  localparam logic [7:0] A_ROUTE = 8'h00;
  localparam logic [7:0] A_HCTL  = 8'h04;
  localparam logic [7:0] A_HCO0  = 8'h08;
  localparam logic [7:0] A_HCO1  = 8'h0c;
  localparam logic [7:0] A_DCTL  = 8'h10;
  localparam logic [7:0] A_DTAP  = 8'h14;
  localparam logic [7:0] A_OFFS  = 8'h18;
  localparam logic [7:0] A_STRT  = 8'h1c;
  localparam logic [7:0] A_STOP  = 8'h20;
  localparam logic [7:0] A_CDAT  = 8'h24;
  localparam logic [7:0] A_STAT  = 8'h28;
  // helper control fields
  localparam int HC_TAP  = 0;
  localparam int HC_SYM  = 3;
  localparam int HC_HALF = 4;
  localparam int HC_BYP  = 5;
  localparam int HC_SCL  = 6;
  // decimating control fields
  localparam int DC_RATE = 0;
  localparam int DC_PHS  = 4;
  localparam int DC_SCL  = 8;
  localparam int DC_SYM  = 10;
  localparam int DC_BYP  = 11;
  // status fields
  localparam int ST_PTR  = 0;
  localparam int ST_BUSY = 8;
  // reset values: both filters bypassed, unity scale
  localparam logic [7:0]  HCTL_RST = 8'he0;
  localparam logic [11:0] DCTL_RST = 12'hb00;
  // binary point of each coefficient format
  localparam logic [5:0] HFRAC = 6'h05;
  localparam logic [5:0] DFRAC = 6'h0d;
  // bus responses
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  typedef enum logic {CBR_IDLE = 1'b0, CBR_MAC = 1'b1} cbr_mac_type;

  // code 00..11 shifts by 3..0, then clamps to the sample width
  function automatic logic [19:0] cbr_scale_sat(input logic signed [47:0] acc,
                                                input logic [5:0]         frac,
                                                input logic [1:0]         code);
    logic signed [47:0] s;
    s = acc >>> (frac + {4'h0, 2'h3 - code});
    if (s > 48'sh7ffff) cbr_scale_sat = 20'h7ffff;
    else if (s < -48'sh80000) cbr_scale_sat = 20'h80000;
    else cbr_scale_sat = s[19:0];
  endfunction : cbr_scale_sat

  // mirrored index; the stored half starts at the centre tap
  function automatic logic [6:0] cbr_sym_index(input logic [6:0] j,
                                               input logic [6:0] nm1);
    logic [6:0] h;
    h = 7'((8'(nm1) + 8'h01) >> 1);
    cbr_sym_index = (j >= h) ? 7'(j - h) : 7'(nm1 - j - h);
  endfunction : cbr_sym_index

  // select word to channel; middle bit ignored for the upper two
  function automatic logic [2:0] cbr_src_index(input logic [2:0] sel);
    cbr_src_index = sel[2] ? {2'b10, sel[0]} : sel;
  endfunction : cbr_src_index
endpackage : cbr_pkg

// ===== cbr_helper_fir.sv
/* cbr_helper_fir: non-decimating serial helper filter, I and Q.
   assumes control and coefficients from the register block on clk. */
`timescale 1ns/1ps
module cbr_helper_fir (
  input  wire logic            clk,
  input  wire logic            sys_rst,
  input  wire logic            in_v,
  input  wire logic [19:0]     in_i,
  input  wire logic [19:0]     in_q,
  input  wire logic [2:0]      taps,
  input  wire logic            sym,
  input  wire logic            half,
  input  wire logic            byp,
  input  wire logic [1:0]      scl,
  input  wire logic [7:0][5:0] coef,
  output logic                 out_v,
  output logic [19:0]          out_i,
  output logic [19:0]          out_q
);
  typedef struct packed {
    cbr_pkg::cbr_mac_type fsm;
    logic                 tick;
    logic [2:0]           k;
    logic [3:0]           shf;
    logic [7:0][19:0]     di;
    logic [7:0][19:0]     dq;
    logic signed [47:0]   ai;
    logic signed [47:0]   aq;
    logic                 ov;
    logic [19:0]          oi;
    logic [19:0]          oq;
  } cbr_hlp_st_type;

  cbr_hlp_st_type     st_r, st_nxt;
  logic [4:0]         didx;
  logic [6:0]         cix;
  logic signed [47:0] pi, pq;

  // one tap of I and Q per enabled cycle
  always_comb begin
    st_nxt = st_r;
    st_nxt.ov = 1'b0;
    st_nxt.tick = ~st_r.tick;
    didx = {2'h0, st_r.k} + {1'b0, st_r.shf};
    // R6 mirror coefficients
    cix = sym ? cbr_pkg::cbr_sym_index({4'h0, st_r.k}, {4'h0, taps}) : {4'h0, st_r.k};
    pi = 48'sh0;
    pq = 48'sh0;
    if (didx < 5'h08) begin
      pi = 48'($signed(st_r.di[didx[2:0]])) * 48'($signed(coef[cix[2:0]]));
      pq = 48'($signed(st_r.dq[didx[2:0]])) * 48'($signed(coef[cix[2:0]]));
    end
    // R5 history; a sample arriving mid-sum restarts the sum below, shf back to 0
    if (in_v) begin
      st_nxt.di = {st_r.di[6:0], in_i};
      st_nxt.dq = {st_r.dq[6:0], in_q};
      st_nxt.shf = 4'(st_r.shf + 4'h1);
    end
    if (byp) begin
      // R9 straight through
      st_nxt.fsm = cbr_pkg::CBR_IDLE;
      if (in_v) begin
        st_nxt.ov = 1'b1;
        st_nxt.oi = in_i;
        st_nxt.oq = in_q;
      end
    end else begin
      unique case (st_r.fsm)
        cbr_pkg::CBR_IDLE: begin
        end
        cbr_pkg::CBR_MAC: begin
          // R7 half rate steps on alternate cycles only
          if (!half || st_r.tick) begin
            st_nxt.ai = st_r.ai + pi;
            st_nxt.aq = st_r.aq + pq;
            st_nxt.k = 3'(st_r.k + 3'h1);
            // R4 stop after field plus one taps
            if (st_r.k == taps) begin
              st_nxt.fsm = cbr_pkg::CBR_IDLE;
              st_nxt.ov = 1'b1;
              // R10 output attenuation
              st_nxt.oi = cbr_pkg::cbr_scale_sat(st_r.ai + pi, cbr_pkg::HFRAC, scl);
              st_nxt.oq = cbr_pkg::cbr_scale_sat(st_r.aq + pq, cbr_pkg::HFRAC, scl);
            end
          end
        end
      endcase
      // R3 a new sample starts a new sum of products
      if (in_v) begin
        st_nxt.fsm = cbr_pkg::CBR_MAC;
        st_nxt.k = 3'h0;
        st_nxt.shf = 4'h0;
        st_nxt.ai = 48'sh0;
        st_nxt.aq = 48'sh0;
      end
    end
    // R26 clear history and strobes
    if (sys_rst) st_nxt = '0;
  end

  // state register
  always_ff @(posedge clk) begin
    st_r <= st_nxt;
  end

  assign out_v = st_r.ov;
  assign out_i = st_r.oi;
  assign out_q = st_r.oq;

  a_hlp_bypass_pass: assert property (@(posedge clk) disable iff (sys_rst) // R9
    byp && in_v |=> out_v && out_i == $past(in_i) && out_q == $past(in_q))
    else $error("helper bypass did not pass the sample");
  a_hlp_half_hold: assert property (@(posedge clk) disable iff (sys_rst) // R7
    half && !byp && !in_v && st_r.fsm == cbr_pkg::CBR_MAC && !st_r.tick
      |=> $stable(st_r.ai) && $stable(st_r.k))
    else $error("helper advanced on an idle half-rate cycle");
  a_hlp_tap_end: assert property (@(posedge clk) disable iff (sys_rst) // R4
    !byp && !in_v && st_r.fsm == cbr_pkg::CBR_MAC && st_r.k == taps && (!half || st_r.tick)
      |=> out_v ##1 !out_v)
    else $error("helper output not one strobe after the last tap");
endmodule : cbr_helper_fir

// ===== cbr_backend.sv
/* cbr_backend: router, helper filter and decimating filter of one channel back end.
   assumes front-end samples on clk and an AXI4-Lite master on the same clock. */
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
// How it works
// R1 - select word 000-011 picks channels 0-3, 1x0 channel 4, 1x1 channel 5
// R2 - any front end may feed this back end, shared with others
// R3 - helper filter: eight-tap non-decimating sum of products, 6-bit coefficients
// R4 - helper computes tap field plus one taps
// R5 - helper takes and gives 20-bit samples
// R6 - helper symmetry mirrors half the stored coefficients
// R7 - half-rate bit runs the helper on alternate cycles
// R8 - software picks half rate only when the tap budget allows it
// R9 - helper bypass passes the input unchanged
// R10 - helper scale code 00/01/10/11 gives 18, 12, 6, 0 dB loss
// R11 - decimating filter uses 20-bit samples, 14-bit coefficients
// R12 - decimating filter computes tap register plus one taps
// R13 - decimation rate is the 4-bit field plus one
// R14 - coefficient storage holds 64 taps, 128 with symmetry
// R15 - decimating symmetry reads only half the impulse response
// R16 - decimating bypass passes input with no scaling
// R17 - decimating scale uses the helper's code mapping
// R18 - coefficient offset is added to every coefficient address
// R19 - offset changes apply from the next output sample
// R20 - 4-bit decimation phase picks which input starts an output
// R21 - one tap per cycle each for I and Q
// R22 - output rate is input rate over decimation rate
// R23 - each coefficient data access steps the address from start to stop
// R24 - byte-wide hosts write the low coefficient byte first; here each A_CDAT write, any strobes, stores a merged word and steps
// R25 - each output sample carries a one-cycle valid strobe
// R26 - reset clears delay lines, counters and valid outputs
`timescale 1ns/1ps
module cbr_backend (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic [5:0]       fe_v,
  input  wire logic [5:0][19:0] fe_i,
  input  wire logic [5:0][19:0] fe_q,
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  output logic                  dec_v,
  output logic [19:0]           dec_i,
  output logic [19:0]           dec_q
);
  typedef struct packed {
    logic [2:0]           src;
    logic [7:0]           hctl;
    logic [7:0][5:0]      hco;
    logic [11:0]          dctl;
    logic [6:0]           ntap;
    logic [5:0]           off;
    logic [5:0]           sta;
    logic [5:0]           stp;
    logic [5:0]           ptr;
    logic [63:0][13:0]    ram;
    logic                 rv;
    logic [19:0]          ri;
    logic [19:0]          rq;
    cbr_pkg::cbr_mac_type fsm;
    logic [3:0]           dcnt;
    logic [6:0]           k;
    logic [6:0]           shf;
    logic [6:0]           nl;
    logic [5:0]           offl;
    logic                 syml;
    logic [127:0][19:0]   di;
    logic [127:0][19:0]   dq;
    logic signed [47:0]   ai;
    logic signed [47:0]   aq;
    logic                 ov;
    logic [19:0]          oi;
    logic [19:0]          oq;
    logic                 awh;
    logic                 wh;
    logic [7:0]           aw;
    logic [31:0]          wd;
    logic [3:0]           ws;
    logic                 awr;
    logic                 wr;
    logic                 bv;
    logic [1:0]           br;
    logic                 arr;
    logic                 rvd;
    logic [31:0]          rd;
    logic [1:0]           rr;
  } cbr_st_type;

  cbr_st_type         st_r, st_nxt;
  logic               h_v;
  logic [19:0]        h_i, h_q;
  logic [3:0]         d_rate, d_phs;
  logic [1:0]         d_scl;
  logic               d_sym, d_byp;
  logic [32:0]        rw;
  logic [31:0]        m;
  logic [7:0]         didx;
  logic [6:0]         cix;
  logic [5:0]         caddr;
  logic [13:0]        cf;
  logic signed [47:0] pi, pq;
  logic               go;
  logic               cacc;

  // register word for reads and byte-lane merging
  function automatic logic [32:0] regword(input logic [7:0] a, input cbr_st_type s);
    logic [31:0] v;
    logic        ok;
    v = 32'h0;
    ok = 1'b1;
    case ({a[7:2], 2'b00})
      cbr_pkg::A_ROUTE: v[2:0] = s.src;
      cbr_pkg::A_HCTL:  v[7:0] = s.hctl;
      cbr_pkg::A_HCO0:  for (int i = 0; i < 4; i++) v[8*i +: 6] = s.hco[i];
      cbr_pkg::A_HCO1:  for (int i = 0; i < 4; i++) v[8*i +: 6] = s.hco[i+4];
      cbr_pkg::A_DCTL:  v[11:0] = s.dctl;
      cbr_pkg::A_DTAP:  v[6:0] = s.ntap;
      cbr_pkg::A_OFFS:  v[5:0] = s.off;
      cbr_pkg::A_STRT:  v[5:0] = s.sta;
      cbr_pkg::A_STOP:  v[5:0] = s.stp;
      cbr_pkg::A_CDAT:  v[13:0] = s.ram[s.ptr];
      cbr_pkg::A_STAT: begin
        v[cbr_pkg::ST_PTR +: 6] = s.ptr;
        v[cbr_pkg::ST_BUSY] = (s.fsm == cbr_pkg::CBR_MAC);
      end
      default: ok = 1'b0;
    endcase
    return {ok, v};
  endfunction : regword

  // coefficient pointer wraps from stop back to start
  function automatic logic [5:0] adv(input logic [5:0] p,
                                     input logic [5:0] stp,
                                     input logic [5:0] sta);
    adv = (p == stp) ? sta : 6'(p + 6'h01);
  endfunction : adv

  // decimating control fields
  assign d_rate = st_r.dctl[cbr_pkg::DC_RATE +: 4];
  assign d_phs  = st_r.dctl[cbr_pkg::DC_PHS +: 4];
  assign d_scl  = st_r.dctl[cbr_pkg::DC_SCL +: 2];
  assign d_sym  = st_r.dctl[cbr_pkg::DC_SYM];
  assign d_byp  = st_r.dctl[cbr_pkg::DC_BYP];

  // helper filter between router and decimator
  cbr_helper_fir u_helper (
    .clk     (clk),
    .sys_rst (sys_rst),
    .in_v    (st_r.rv),
    .in_i    (st_r.ri),
    .in_q    (st_r.rq),
    .taps    (st_r.hctl[cbr_pkg::HC_TAP +: 3]),
    .sym     (st_r.hctl[cbr_pkg::HC_SYM]),
    .half    (st_r.hctl[cbr_pkg::HC_HALF]),
    .byp     (st_r.hctl[cbr_pkg::HC_BYP]),
    .scl     (st_r.hctl[cbr_pkg::HC_SCL +: 2]),
    .coef    (st_r.hco),
    .out_v   (h_v),
    .out_i   (h_i),
    .out_q   (h_q)
  );

  // whole next state: bus slave, router, decimating filter
  always_comb begin
    st_nxt = st_r;
    rw = 33'h0;
    m = 32'h0;
    cacc = 1'b0;
    go = 1'b0;

    // R1 source decode
    // R2 mux registered once, free choice
    st_nxt.rv = fe_v[cbr_pkg::cbr_src_index(st_r.src)];
    st_nxt.ri = fe_i[cbr_pkg::cbr_src_index(st_r.src)];
    st_nxt.rq = fe_q[cbr_pkg::cbr_src_index(st_r.src)];

    // write address and data taken in either order
    if (st_r.bv && s_axi_bready) st_nxt.bv = 1'b0;
    if (s_axi_awvalid && st_r.awr) begin
      st_nxt.awh = 1'b1;
      st_nxt.aw = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_r.wr) begin
      st_nxt.wh = 1'b1;
      st_nxt.wd = s_axi_wdata;
      st_nxt.ws = s_axi_wstrb;
    end
    if (st_r.awh && st_r.wh && !st_r.bv) begin
      rw = regword(st_r.aw, st_r);
      for (int b = 0; b < 4; b++) m[8*b +: 8] = st_r.ws[b] ? st_r.wd[8*b +: 8] : rw[8*b +: 8];
      st_nxt.awh = 1'b0;
      st_nxt.wh = 1'b0;
      st_nxt.bv = 1'b1;
      st_nxt.br = rw[32] ? cbr_pkg::RESP_OK : cbr_pkg::RESP_ERR;
      case ({st_r.aw[7:2], 2'b00})
        cbr_pkg::A_ROUTE: st_nxt.src = m[2:0];
        cbr_pkg::A_HCTL:  st_nxt.hctl = m[7:0];
        cbr_pkg::A_HCO0:  for (int i = 0; i < 4; i++) st_nxt.hco[i] = m[8*i +: 6];
        cbr_pkg::A_HCO1:  for (int i = 0; i < 4; i++) st_nxt.hco[i+4] = m[8*i +: 6];
        cbr_pkg::A_DCTL:  st_nxt.dctl = m[11:0];
        cbr_pkg::A_DTAP:  st_nxt.ntap = m[6:0];
        cbr_pkg::A_OFFS:  st_nxt.off = m[5:0];
        cbr_pkg::A_STRT: begin
          st_nxt.sta = m[5:0];
          st_nxt.ptr = m[5:0];
        end
        cbr_pkg::A_STOP:  st_nxt.stp = m[5:0];
        // R23 write then step the pointer
        cbr_pkg::A_CDAT: begin
          st_nxt.ram[st_r.ptr] = m[13:0];
          st_nxt.ptr = adv(st_r.ptr, st_r.stp, st_r.sta);
          cacc = 1'b1;
        end
        default: ;
      endcase
    end
    st_nxt.awr = !st_nxt.awh;
    st_nxt.wr = !st_nxt.wh;

    // read channel; a coefficient read also steps the pointer
    if (st_r.rvd && s_axi_rready) st_nxt.rvd = 1'b0;
    if (s_axi_arvalid && st_r.arr) begin
      rw = regword(s_axi_araddr, st_r);
      st_nxt.rvd = 1'b1;
      st_nxt.rd = rw[31:0];
      st_nxt.rr = rw[32] ? cbr_pkg::RESP_OK : cbr_pkg::RESP_ERR;
      // R23 read steps too
      if ({s_axi_araddr[7:2], 2'b00} == cbr_pkg::A_CDAT) begin
        st_nxt.ptr = adv(st_nxt.ptr, st_r.stp, st_r.sta);
        cacc = 1'b1;
      end
    end
    st_nxt.arr = !st_nxt.rvd;

    // tap operands; samples that arrived mid-sum shift the index
    didx = {1'b0, st_r.k} + {1'b0, st_r.shf};
    // R15 mirrored half when symmetric, reverse order otherwise
    cix = st_r.syml ? cbr_pkg::cbr_sym_index(st_r.k, st_r.nl) : 7'(st_r.nl - st_r.k);
    // R18 offset added to every coefficient address
    // R14 64-entry storage, index wraps
    caddr = 6'(st_r.offl + cix[5:0]);
    cf = st_r.ram[caddr];
    pi = 48'sh0;
    pq = 48'sh0;
    // R11 20-bit samples by 14-bit coefficients
    // R21 two multipliers, one tap per cycle
    if (didx < 8'(cbr_pkg::NDL)) begin
      pi = 48'($signed(st_r.di[didx[6:0]])) * 48'($signed(cf));
      pq = 48'($signed(st_r.dq[didx[6:0]])) * 48'($signed(cf));
    end

    st_nxt.ov = 1'b0;
    if (h_v) begin
      st_nxt.di = {st_r.di[126:0], h_i};
      st_nxt.dq = {st_r.dq[126:0], h_q};
      st_nxt.shf = 7'(st_r.shf + 7'h01);
    end
    if (d_byp) begin
      // R16 straight through, no scaling, no decimation
      st_nxt.fsm = cbr_pkg::CBR_IDLE;
      st_nxt.dcnt = 4'h0;
      if (h_v) begin
        st_nxt.ov = 1'b1;
        st_nxt.oi = h_i;
        st_nxt.oq = h_q;
      end
    end else begin
      unique case (st_r.fsm)
        cbr_pkg::CBR_IDLE: begin
        end
        cbr_pkg::CBR_MAC: begin
          st_nxt.ai = st_r.ai + pi;
          st_nxt.aq = st_r.aq + pq;
          st_nxt.k = 7'(st_r.k + 7'h01);
          // R12 last tap is the tap register value
          if (st_r.k == st_r.nl) begin
            st_nxt.fsm = cbr_pkg::CBR_IDLE;
            // R25 one-cycle strobe with the sample
            st_nxt.ov = 1'b1;
            // R17 same attenuation codes as the helper
            st_nxt.oi = cbr_pkg::cbr_scale_sat(st_r.ai + pi, cbr_pkg::DFRAC, d_scl);
            st_nxt.oq = cbr_pkg::cbr_scale_sat(st_r.aq + pq, cbr_pkg::DFRAC, d_scl);
          end
        end
      endcase
      if (h_v) begin
        // R13 counter wraps at rate field
        st_nxt.dcnt = (st_r.dcnt == d_rate) ? 4'h0 : 4'(st_r.dcnt + 4'h1);
        // R20 phase picks the starting input
        // R22 one start per rate inputs
        go = (st_r.dcnt == d_phs);
      end
      if (go) begin
        st_nxt.fsm = cbr_pkg::CBR_MAC;
        st_nxt.k = 7'h00;
        st_nxt.shf = 7'h00;
        st_nxt.ai = 48'sh0;
        st_nxt.aq = 48'sh0;
        st_nxt.nl = st_r.ntap;
        // R19 offset latched per output sample
        st_nxt.offl = st_r.off;
        st_nxt.syml = d_sym;
      end
    end

    // R26 synchronous clear, filters bypassed
    if (sys_rst) begin
      st_nxt = '0;
      st_nxt.hctl = cbr_pkg::HCTL_RST;
      st_nxt.dctl = cbr_pkg::DCTL_RST;
    end
  end

  // single state register; reset is folded into the next state
  always_ff @(posedge clk) begin
    st_r <= st_nxt;
  end

  // outputs straight from the state register
  assign s_axi_awready = st_r.awr;
  assign s_axi_wready  = st_r.wr;
  assign s_axi_bvalid  = st_r.bv;
  assign s_axi_bresp   = st_r.br;
  assign s_axi_arready = st_r.arr;
  assign s_axi_rvalid  = st_r.rvd;
  assign s_axi_rdata   = st_r.rd;
  assign s_axi_rresp   = st_r.rr;
  assign dec_v         = st_r.ov;
  assign dec_i         = st_r.oi;
  assign dec_q         = st_r.oq;

  a_dec_bypass_pass: assert property (@(posedge clk) disable iff (sys_rst) // R16
    d_byp && h_v |=> dec_v && dec_i == $past(h_i) && dec_q == $past(h_q))
    else $error("decimator bypass did not pass the sample");
  a_dec_last_tap: assert property (@(posedge clk) disable iff (sys_rst) // R12
    !d_byp && !go && st_r.fsm == cbr_pkg::CBR_MAC && st_r.k == st_r.nl
      |=> dec_v ##1 (!dec_v || $past(go)))
    else $error("decimator output not one strobe after the last tap");
  a_dec_phase_go: assert property (@(posedge clk) disable iff (sys_rst) // R20
    !d_byp && h_v && st_r.dcnt == d_phs
      |=> st_r.fsm == cbr_pkg::CBR_MAC && st_r.k == 7'h00 && st_r.offl == $past(st_r.off))
    else $error("sum did not start on the phase input");
  a_dec_offset_hold: assert property (@(posedge clk) disable iff (sys_rst) // R19
    st_r.k != 7'h00 |-> $stable(st_r.offl) && $stable(st_r.nl))
    else $error("coefficient offset changed inside a sum");
  a_coef_ptr_step: assert property (@(posedge clk) disable iff (sys_rst) // R23
    cacc && !(st_r.awh && st_r.wh && !st_r.bv && s_axi_arvalid && st_r.arr)
      && st_r.ptr != st_r.stp |=> st_r.ptr == 6'($past(st_r.ptr) + 6'h01))
    else $error("coefficient pointer did not step");
  a_reset_clear: assert property (@(posedge clk) // R26
    sys_rst |=> !dec_v && st_r.dcnt == 4'h0 && st_r.fsm == cbr_pkg::CBR_IDLE && !s_axi_bvalid)
    else $error("reset left the back end active");
endmodule : cbr_backend

// ===== cbr_fe_model.sv
/* cbr_fe_model: front-end cascade stand-in feeding all six channels.
   assumes go is driven by the bench right after a clock edge. */
`timescale 1ns/1ps
module cbr_fe_model (
  input  wire logic             clk,
  input  wire logic             go,
  input  wire logic [19:0]      smp,
  output logic      [5:0]       fe_v,
  output logic      [5:0][19:0] fe_i,
  output logic      [5:0][19:0] fe_q
);
  // one strobe per go; data inverts outside it so stale values never pass
  always_ff @(posedge clk) begin
    fe_v <= {6{go}};
    for (int c = 0; c < 6; c++) begin
      fe_i[c] <= go ? smp + 20'(c * 256) : ~fe_i[c];
      fe_q[c] <= go ? 20'h0 - smp - 20'(c * 256) : ~fe_q[c];
    end
  end
endmodule : cbr_fe_model

// ===== tb_top.sv
/* tb_top: self-checking bench for cbr_backend.
   assumes the front-end model and a 40 MHz clock; downstream never stalls. */
`timescale 1ns/1ps
module tb_top;
  logic             clk = 0;
  logic             sys_rst = 1;
  logic             go = 0;
  logic [19:0]      smp = 0;
  logic [5:0]       fe_v;
  logic [5:0][19:0] fe_i, fe_q;
  logic [7:0]       awaddr = 0, araddr = 0;
  logic [31:0]      wdata = 0, rdata, rd;
  logic             awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic             awready, wready, bvalid, arready, rvalid, dec_v;
  logic [1:0]       bresp, rresp, rr, br;
  logic [19:0]      dec_i, dec_q, e;
  int               n_mismatch = 0;
  int               n_tests = 0;
  always #12.5 clk = ~clk;
  cbr_fe_model fe (.clk(clk), .go(go), .smp(smp), .fe_v(fe_v), .fe_i(fe_i), .fe_q(fe_q));
  cbr_backend uut (.clk(clk), .sys_rst(sys_rst), .fe_v(fe_v), .fe_i(fe_i), .fe_q(fe_q),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .dec_v(dec_v), .dec_i(dec_i), .dec_q(dec_q));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // write: address and data offered together, each dropped once taken
  // bready stays high once raised, so back-to-back calls never toggle it
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    br = bresp;
  endtask : axw
  // read: rready likewise stays high between reads
  task automatic axr(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rr = rresp;
  endtask : axr
  // one front-end sample, then wait for the output strobe
  task automatic shot(input logic [19:0] s);
    int n;
    n = 0;
    smp <= s;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (dec_v !== 1'b1 && n < 60);
    chk({31'h0, dec_v}, 32'h1);
  endtask : shot
  task automatic t_regs;
    chk({31'h0, dec_v}, 32'h0);
    axr(cbr_pkg::A_HCTL);
    chk(rd, 32'h000000e0);
    axr(cbr_pkg::A_DCTL);
    chk(rd, 32'h00000b00);
    axr(8'h3c);
    chk({30'h0, rr}, {30'h0, cbr_pkg::RESP_ERR});
    axw(8'h3c, 32'h0);
    chk({30'h0, br}, {30'h0, cbr_pkg::RESP_ERR});
    $display("t_regs done");
  endtask : t_regs
  // every select code, including the ignored middle bit
  task automatic t_route;
    for (int s = 0; s < 8; s++) begin
      axw(cbr_pkg::A_ROUTE, 32'(s));
      e = 20'h00123 + 20'((s > 3 ? 4 + s % 2 : s) * 256);
      shot(20'h00123);
      chk({12'h0, dec_i}, {12'h0, e});
      chk({12'h0, dec_q}, {12'h0, 20'h0 - e});
    end
    $display("t_route done");
  endtask : t_route
  // one tap of 0.5, each scale code in turn
  task automatic t_scale;
    axw(cbr_pkg::A_ROUTE, 32'h0);
    axw(cbr_pkg::A_HCO0, 32'h10);
    for (int c = 0; c < 4; c++) begin
      axw(cbr_pkg::A_HCTL, 32'(c * 64));
      e = 20'h00800 >> (3 - c);
      shot(20'h01000);
      chk({12'h0, dec_i}, {12'h0, e});
      chk({12'h0, dec_q}, {12'h0, 20'h0 - e});
    end
    // three mirrored taps 0.25, 0.5, 0.25 at half rate on a flat history
    axw(cbr_pkg::A_HCO0, 32'h0810);
    axw(cbr_pkg::A_HCTL, 32'hda);
    shot(20'h01000);
    chk({12'h0, dec_i}, {12'h0, 20'h01000});
    $display("t_scale done");
  endtask : t_scale
  // decimate by two: four inputs give two outputs, coefficient at offset
  task automatic t_decim(input logic [5:0] off, input logic [13:0] cf, input logic [19:0] x);
    int n;
    n = 0;
    axw(cbr_pkg::A_HCTL, 32'he0);
    axw(cbr_pkg::A_STRT, 32'(off));
    axw(cbr_pkg::A_STOP, 32'(off) + 32'h1);
    axw(cbr_pkg::A_CDAT, 32'(cf));
    axr(cbr_pkg::A_STAT);
    chk(rd, 32'(off) + 32'h1);
    axw(cbr_pkg::A_OFFS, 32'(off));
    axw(cbr_pkg::A_DTAP, 32'h0);
    axw(cbr_pkg::A_DCTL, 32'h301);
    chk({30'h0, br}, {30'h0, cbr_pkg::RESP_OK});
    repeat (4) begin
      smp <= 20'h01000;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (9) begin
        @(posedge clk);
        if (dec_v === 1'b1) begin
          n++;
          e = dec_i;
        end
      end
    end
    chk(32'(n), 32'h2);
    chk({12'h0, e}, {12'h0, x});
    $display("t_decim done");
  endtask : t_decim
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_regs;
    t_route;
    t_scale;
    t_decim(6'h00, 14'h1000, 20'h00800);
    t_decim(6'h01, 14'h0800, 20'h00400);
    end_sim;
  end
  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (6000) @(posedge clk);
    n_mismatch++;
    end_sim;
  end
endmodule : tb_top
